// ===== verilog/rdsro_pkg.sv
package rdsro_pkg;

  // Bus map (byte addresses)
  localparam logic [4:0] RDSRO_OFS_STATUS = 5'h00;
  localparam logic [4:0] RDSRO_OFS_CLEAR  = 5'h04;
  localparam logic [4:0] RDSRO_OFS_ENABLE = 5'h08;
  localparam logic [4:0] RDSRO_OFS_STATE  = 5'h0C;

  // Event bit positions, shared by status, clear and enable
  localparam int RDSRO_EV_W = 4;
  localparam logic [RDSRO_EV_W-1:0] RDSRO_EV_RST = 4'h0;

  // State register fields
  localparam int RDSRO_ST_READY = 0;
  localparam int RDSRO_ST_RELY  = 1;
  localparam int RDSRO_ST_ARMED = 2;
  localparam int RDSRO_ST_MODE  = 4;
  localparam int RDSRO_ST_FILL  = 8;

  // Buffer geometry
  localparam int RDSRO_DEPTH = 128;
  localparam int RDSRO_CNT_W = 8;

  // Timing
  localparam int RDSRO_CLK_NS       = 50;
  localparam int RDSRO_PHASE_NS     = 2000;
  localparam int RDSRO_PHASE_CYC    = (RDSRO_PHASE_NS + RDSRO_CLK_NS - 1) / RDSRO_CLK_NS;
  localparam int RDSRO_RDY_CHECK_NS = 750;
  localparam int RDSRO_RDY_CHECK_CYC = RDSRO_RDY_CHECK_NS / RDSRO_CLK_NS;
  localparam int RDSRO_PH_W         = 6;

  typedef enum logic [1:0] {
    RDSRO_MASTER,
    RDSRO_SLAVE,
    RDSRO_STANDBY,
    RDSRO_TEST
  } rdsro_mode_e;

  typedef enum logic [1:0] {
    RDSRO_M_IDLE,
    RDSRO_M_HIGH,
    RDSRO_M_LOW
  } rdsro_mst_e;

  // Pins from outside the clock domain
  typedef struct packed {
    logic factory_sel;
    logic mode;
    logic clear;
    logic sclk;
  } rdsro_pins_s;

  typedef struct packed {
    logic drained;
    logic overflow;
    logic detect;
    logic ready_rise;
  } rdsro_evt_s;

endpackage

// ===== verilog/rdsro_sync2.sv
`timescale 1ns/10ps
module rdsro_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         resetn,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// ===== verilog/rdsro_bitfifo.sv
`timescale 1ns/10ps
module rdsro_bitfifo (
  // Clock and reset
  input  wire logic                            clock,
  input  wire logic                            resetn,
  // Control
  input  wire logic                            flush,
  input  wire logic                            push,
  input  wire logic                            din,
  input  wire logic                            pop,
  // State
  output logic                                 dout,
  output logic                                 empty,
  output logic                                 full,
  output logic [rdsro_pkg::RDSRO_CNT_W-1:0]    count
);
  import rdsro_pkg::*;

  localparam int AW = RDSRO_CNT_W - 1;

  logic          mem [RDSRO_DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic          do_push;
  logic          do_pop;

  assign empty   = (count == '0);
  assign full    = (count == RDSRO_CNT_W'(RDSRO_DEPTH));
  assign do_push = push && !full;
  assign do_pop  = pop && !empty;
  assign dout    = mem[rd_q];

  always_ff @(posedge clock) begin
    if (do_push) begin
      mem[wr_q] <= din;
    end
  end

  // Oldest bit leaves first
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wr_q  <= '0;
      rd_q  <= '0;
      count <= '0;
    end else if (flush) begin
      wr_q  <= '0;
      rd_q  <= '0;
      count <= '0;
    end else begin
      if (do_push) begin
        wr_q <= wr_q + AW'(1);
      end
      if (do_pop) begin
        rd_q <= rd_q + AW'(1);
      end
      count <= count + RDSRO_CNT_W'(do_push) - RDSRO_CNT_W'(do_pop);
    end
  end
endmodule

// ===== verilog/rdsro_core.sv
// Operation
// - Select pin low: mode low gives master, mode high gives slave readout.
// - Select high, mode low: standby, oscillator halted, clock and status pins idle.
// - Reset pin high clears detector, demodulation; in slave also ready and buffer.
// - Status pin active high: reliability in master, ready in slave.
// - Master after reset holds clock and data high until detection.
// - Slave data stable for capture on either edge of host clock.
// - Ready drops after last stored bit read, rises when one bit stored.
// - Nothing stored until first detection; storing then continues regardless.
// - Mode may change between master and slave mid-readout without loss; leaving master before the clock falls drops the popped bit.
// - After master to slave, slave continues with the very next bit.
// - Clock pin driven in master, sampled as readout clock in slave; the code releases it in master while the reset pin is high.
//
// The Avalon-MM interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module rdsro_core (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  // Avalon-MM slave
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Mode and reset pins
  input  wire logic        factory_sel_pin,
  input  wire logic        mode_pin,
  input  wire logic        reset_pin,
  // Serial link
  input  wire logic        serial_clock_pin_i,
  output logic             serial_clock_pin_o,
  output logic             serial_clock_pin_oe,
  output logic             serial_data_out,
  output logic             status_pin_o,
  output logic             status_pin_oe,
  // Demodulator side
  input  wire logic        rx_bit,
  input  wire logic        rx_bit_valid,
  input  wire logic        signal_detect,
  // System
  output logic             osc_enable,
  output logic             irq
);
  import rdsro_pkg::*;

  rdsro_pins_s              pins_raw;
  rdsro_pins_s              pins_s;
  rdsro_mode_e              mode_d;
  rdsro_mode_e              mode_q;
  rdsro_mst_e               mst_q;
  rdsro_evt_s               evt;
  logic [RDSRO_PH_W-1:0]    phase_q;
  logic                     rely_q;
  logic                     armed_q;
  logic                     ready_q;
  logic                     sclk_prev_q;
  logic                     is_master;
  logic                     is_slave;
  logic                     clr;
  logic                     fifo_push;
  logic                     fifo_pop;
  logic                     fifo_flush;
  logic                     fifo_dout;
  logic                     fifo_empty;
  logic                     fifo_full;
  logic [RDSRO_CNT_W-1:0]   fifo_count;
  logic                     mst_pop;
  logic                     slv_pop;
  logic                     phase_done;
  logic [RDSRO_EV_W-1:0]    sts_q;
  logic [RDSRO_EV_W-1:0]    en_q;
  logic [RDSRO_EV_W-1:0]    clr_mask;
  logic                     bus_req;
  logic                     bus_take;
  logic [31:0]              rd_mux;

  // Pins first pass two flops
  assign pins_raw = '{factory_sel: factory_sel_pin,
                      mode:        mode_pin,
                      clear:       reset_pin,
                      sclk:        serial_clock_pin_i};

  rdsro_sync2 #(
    .W ($bits(rdsro_pins_s))
  ) u_pin_sync (
    .clock  (clock),
    .resetn (resetn),
    .d      (pins_raw),
    .q      (pins_s)
  );

  assign clr = pins_s.clear;

  // Mode decode
  always_comb begin
    unique case ({pins_s.factory_sel, pins_s.mode})
      2'b00: mode_d = RDSRO_MASTER;
      2'b01: mode_d = RDSRO_SLAVE;
      2'b10: mode_d = RDSRO_STANDBY;
      2'b11: mode_d = RDSRO_TEST;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mode_q <= RDSRO_STANDBY;
    end else begin
      mode_q <= mode_d;
    end
  end

  assign is_master = (mode_q == RDSRO_MASTER);
  assign is_slave  = (mode_q == RDSRO_SLAVE);

  // Test combination keeps the oscillator running, unlike standby; its clock and status pins are released
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      osc_enable <= 1'b0;
    end else begin
      osc_enable <= (mode_d != RDSRO_STANDBY);
    end
  end

  // Reliability detector, cleared by the reset pin
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rely_q <= 1'b0;
    end else if (clr) begin
      rely_q <= 1'b0;
    end else begin
      rely_q <= signal_detect && osc_enable;
    end
  end

  // Storage armed by first detection and kept after loss
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      armed_q <= 1'b0;
    end else if (clr) begin
      armed_q <= 1'b0;
    end else if (rely_q) begin
      armed_q <= 1'b1;
    end
  end

  assign fifo_push  = armed_q && rx_bit_valid && !clr && osc_enable;
  assign fifo_flush = clr && is_slave;
  assign fifo_pop   = mst_pop || slv_pop;

  rdsro_bitfifo u_buf (
    .clock  (clock),
    .resetn (resetn),
    .flush  (fifo_flush),
    .push   (fifo_push),
    .din    (rx_bit),
    .pop    (fifo_pop),
    .dout   (fifo_dout),
    .empty  (fifo_empty),
    .full   (fifo_full),
    .count  (fifo_count)
  );

  // Master sequencer: data set with clock high, host takes it on the fall
  assign phase_done = (phase_q == RDSRO_PH_W'(RDSRO_PHASE_CYC - 1));
  assign mst_pop    = is_master && armed_q && !clr && (mst_q == RDSRO_M_IDLE)
                      && !fifo_empty;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mst_q   <= RDSRO_M_IDLE;
      phase_q <= '0;
    end else if (!is_master || clr) begin
      // Leaving master mid-bit returns to idle; the popped bit is lost unless the clock already fell
      mst_q   <= RDSRO_M_IDLE;
      phase_q <= '0;
    end else begin
      unique case (mst_q)
        RDSRO_M_IDLE: begin
          phase_q <= '0;
          if (mst_pop) begin
            mst_q <= RDSRO_M_HIGH;
          end
        end
        RDSRO_M_HIGH: begin
          phase_q <= phase_done ? '0 : phase_q + RDSRO_PH_W'(1);
          if (phase_done) begin
            mst_q <= RDSRO_M_LOW;
          end
        end
        RDSRO_M_LOW: begin
          phase_q <= phase_done ? '0 : phase_q + RDSRO_PH_W'(1);
          if (phase_done) begin
            mst_q <= RDSRO_M_IDLE;
          end
        end
      endcase
    end
  end

  // Clock pin: driven in master while the reset pin is low, released otherwise
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      serial_clock_pin_oe <= 1'b0;
      serial_clock_pin_o  <= 1'b1;
    end else begin
      serial_clock_pin_oe <= is_master && !clr;
      serial_clock_pin_o  <= (mst_q != RDSRO_M_LOW) || !armed_q;
    end
  end

  // Slave readout clock edges, from the synchronised copy only
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= pins_s.sclk;
    end
  end

  // Advance after the falling edge so the bit stood across both edges
  assign slv_pop = is_slave && ready_q && sclk_prev_q && !pins_s.sclk
                   && !clr;

  // Data pin: head bit in slave, popped bit in master
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      serial_data_out <= 1'b1;
    end else if (is_master) begin
      if (clr || !armed_q) begin
        serial_data_out <= 1'b1;
      end else if (mst_pop) begin
        serial_data_out <= fifo_dout;
      end
    end else if (is_slave && !fifo_empty) begin
      serial_data_out <= fifo_dout;
    end
  end

  // Ready follows buffer occupancy once armed
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= is_slave && armed_q && !clr && !fifo_empty
                 && !(slv_pop && (fifo_count == RDSRO_CNT_W'(1)));
    end
  end

  // Open-drain status: pull low when the active-high level is false
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      status_pin_o  <= 1'b0;
      status_pin_oe <= 1'b0;
    end else begin
      status_pin_o  <= 1'b0;
      unique case (mode_q)
        RDSRO_MASTER:  status_pin_oe <= !rely_q;
        RDSRO_SLAVE:   status_pin_oe <= !ready_q;
        RDSRO_STANDBY: status_pin_oe <= 1'b0;
        RDSRO_TEST:    status_pin_oe <= 1'b0;
      endcase
    end
  end

  // Events for the interrupt block
  logic ready_prev_q;
  logic armed_prev_q;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ready_prev_q <= 1'b0;
      armed_prev_q <= 1'b0;
    end else begin
      ready_prev_q <= ready_q;
      armed_prev_q <= armed_q;
    end
  end

  assign evt.ready_rise = ready_q && !ready_prev_q;
  assign evt.detect     = armed_q && !armed_prev_q;
  assign evt.overflow   = fifo_push && fifo_full;
  assign evt.drained    = !ready_q && ready_prev_q;

  // Bus: one wait cycle, then the access completes
  assign bus_req  = read || write;
  assign bus_take = bus_req && !waitrequest;
  assign clr_mask = (write && !waitrequest && address == RDSRO_OFS_CLEAR)
                    ? writedata[RDSRO_EV_W-1:0] : RDSRO_EV_RST;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= !(bus_req && waitrequest);
    end
  end

  always_comb begin
    rd_mux = 32'h00000000;
    unique case (address)
      RDSRO_OFS_STATUS: rd_mux[RDSRO_EV_W-1:0] = sts_q;
      RDSRO_OFS_ENABLE: rd_mux[RDSRO_EV_W-1:0] = en_q;
      RDSRO_OFS_STATE: begin
        rd_mux[RDSRO_ST_READY]                  = ready_q;
        rd_mux[RDSRO_ST_RELY]                   = rely_q;
        rd_mux[RDSRO_ST_ARMED]                  = armed_q;
        rd_mux[RDSRO_ST_MODE +: 2]              = mode_q;
        rd_mux[RDSRO_ST_FILL +: RDSRO_CNT_W]    = fifo_count;
      end
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      readdata <= 32'h00000000;
    end else if (read && waitrequest) begin
      readdata <= rd_mux;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      en_q <= RDSRO_EV_RST;
    end else if (bus_take && write && address == RDSRO_OFS_ENABLE) begin
      en_q <= writedata[RDSRO_EV_W-1:0];
    end
  end

  // Set beats clear in the same cycle
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sts_q <= RDSRO_EV_RST;
    end else begin
      sts_q <= (sts_q & ~clr_mask) | evt;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((sts_q & ~clr_mask) | evt) & en_q);
    end
  end

endmodule

// ===== tb/rdsro_assertions.sv
`timescale 1ns/10ps
module rdsro_assertions (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Bus handshake
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  // Pins
  input wire logic factory_sel_pin,
  input wire logic mode_pin,
  input wire logic reset_pin,
  input wire logic signal_detect,
  input wire logic serial_clock_pin_i,
  input wire logic serial_clock_pin_o,
  input wire logic serial_clock_pin_oe,
  input wire logic serial_data_out,
  input wire logic status_pin_oe,
  input wire logic osc_enable
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  logic [7:0] low_q;
  // Length of the driven low phase
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn)
      low_q <= 8'h00;
    else if (serial_clock_pin_oe && !serial_clock_pin_o)
      low_q <= low_q + 8'h01;
    else
      low_q <= 8'h00;
  end
  sequence s_ack;
    !waitrequest ##1 waitrequest;
  endsequence
  sequence s_mst;
    (!factory_sel_pin && !mode_pin && !reset_pin) [*6];
  endsequence
  sequence s_cleared;
    (reset_pin && !mode_pin && !factory_sel_pin)
      ##1 (!signal_detect && !reset_pin && !mode_pin && !factory_sel_pin) [*8];
  endsequence
  property p_bus;
    (read || write) && waitrequest |=> s_ack;
  endproperty
  a_bus: assert property (p_bus) else $error("bus ack not one cycle");
  property p_standby;
    (factory_sel_pin && !mode_pin) [*6] |-> !osc_enable && !status_pin_oe && !serial_clock_pin_oe;
  endproperty
  a_standby: assert property (p_standby) else $error("standby not idle");
  property p_run_osc;
    (!factory_sel_pin) [*6] |-> osc_enable;
  endproperty
  a_run_osc: assert property (p_run_osc) else $error("oscillator stopped");
  property p_master;
    s_mst |-> serial_clock_pin_oe;
  endproperty
  a_master: assert property (p_master) else $error("clock pin not driven");
  property p_slave;
    (mode_pin && !factory_sel_pin) [*6] |-> !serial_clock_pin_oe;
  endproperty
  a_slave: assert property (p_slave) else $error("clock pin driven in slave");
  property p_data_low;
    serial_clock_pin_oe && !serial_clock_pin_o && $past(serial_clock_pin_oe)
      |-> $stable(serial_data_out);
  endproperty
  a_data_low: assert property (p_data_low) else $error("data moved in low phase");
  property p_low;
    $rose(serial_clock_pin_o) && serial_clock_pin_oe && low_q != 8'h00
      |-> low_q == 8'(rdsro_pkg::RDSRO_PHASE_CYC);
  endproperty
  a_low: assert property (p_low) else $error("low phase length wrong");
  property p_idle;
    s_cleared |-> serial_clock_pin_o && serial_data_out;
  endproperty
  a_idle: assert property (p_idle) else $error("lines not high after clear");
  property p_rst_slave;
    (mode_pin && !factory_sel_pin && reset_pin) [*6] |-> status_pin_oe;
  endproperty
  a_rst_slave: assert property (p_rst_slave) else $error("ready not cleared");
  property p_slave_data;
    (mode_pin && !factory_sel_pin && serial_clock_pin_i) [*8] |-> $stable(serial_data_out);
  endproperty
  a_slave_data: assert property (p_slave_data) else $error("data moved in high");
endmodule
bind rdsro_core rdsro_assertions u_chk (.*);

// ===== tb/rdsro_host.sv
`timescale 1ns/10ps
module rdsro_host (
  // Clock
  input  wire logic clock,
  // Host controls
  input  wire logic en,
  input  wire logic slow,
  // Pins
  input  wire logic ready,
  input  wire logic clk_pin,
  input  wire logic data_pin,
  output logic      clk_drv,
  // Captured bits
  output logic      cap_stb,
  output logic      cap_bit
);
  logic prev_q;
  // Bit taken where the pin clock falls, in either mode
  always @(posedge clock) begin
    prev_q <= clk_pin;
    cap_stb <= prev_q && !clk_pin;
    cap_bit <= data_pin;
  end
  initial begin
    clk_drv = 1'b0;
    forever begin
      @(posedge clock);
      if (en && ready) begin
        clk_drv <= 1'b1;
        repeat (slow ? 40 : 16) @(posedge clock);
        clk_drv <= 1'b0;
        // Ready is only trusted after the check delay
        repeat (rdsro_pkg::RDSRO_RDY_CHECK_CYC + 1) @(posedge clock);
      end
    end
  end
endmodule

// ===== tb/rds_serial_readout_tb.sv
`timescale 1ns/10ps
module rds_serial_readout_tb;
  import rdsro_pkg::*;
  logic        clock, resetn, read, write, waitrequest, factory_sel_pin, mode_pin;
  logic        reset_pin, serial_clock_pin_o, serial_clock_pin_oe, serial_data_out;
  logic        status_pin_o, status_pin_oe, rx_bit, rx_bit_valid, signal_detect;
  logic        osc_enable, irq, h_en, h_slow, h_drv, cap_stb, cap_bit;
  logic        serial_clock_pin_i, ready;
  logic [4:0]  address;
  logic [31:0] writedata, readdata, rd;
  logic [15:0] got;
  int          error_cnt, checked, ncap, mark;
  // Select, mode, oscillator, mode field
  logic [4:0]  rows [4] = '{5'h04, 5'h0D, 5'h12, 5'h1F};
  assign serial_clock_pin_i = serial_clock_pin_oe ? serial_clock_pin_o : h_drv;
  // Open drain with pull-up
  assign ready = !status_pin_oe;
  rdsro_core u_dut (.*);
  rdsro_host u_host (.clock, .en(h_en), .slow(h_slow), .ready, .clk_pin(serial_clock_pin_i),
                     .data_pin(serial_data_out), .clk_drv(h_drv), .cap_stb, .cap_bit);
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock) begin
    if (cap_stb) begin
      got <= {got[14:0], cap_bit};
      ncap <= ncap + 1;
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic end_of_test();
    $display("checked=%0d error_cnt=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
    if (waitrequest !== 1'b0) begin
      error_cnt++;
      end_of_test();
    end
  endtask
  task automatic push(input logic [7:0] b);
    for (int k = 7; k >= 0; k--) begin
      @(posedge clock);
      rx_bit <= b[k];
      rx_bit_valid <= 1'b1;
      @(posedge clock);
      rx_bit_valid <= 1'b0;
    end
  endtask
  task automatic wait_cap(input int n);
    int t;
    t = 0;
    while (ncap - mark < n && t < 5000) begin
      @(posedge clock);
      t++;
    end
    if (ncap - mark < n) begin
      error_cnt++;
      end_of_test();
    end
  endtask
  task automatic pulse_rst();
    reset_pin <= 1'b1;
    cyc(8);
    reset_pin <= 1'b0;
    cyc(6);
  endtask
  initial begin
    resetn = 1'b0;
    {read, write, address, writedata, factory_sel_pin, mode_pin, reset_pin} = '0;
    {rx_bit, rx_bit_valid, signal_detect, h_en, h_slow} = '0;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      factory_sel_pin <= rows[i][4];
      mode_pin <= rows[i][3];
      cyc(8);
      bus(1'b0, RDSRO_OFS_STATE, 32'h0);
      chk(32'(rd[5:4]), 32'(rows[i][1:0]));
      chk(32'(osc_enable), 32'(rows[i][2]));
    end
    // Test combination only probed above; never driven again
    factory_sel_pin <= 1'b0;
    mode_pin <= 1'b0;
    cyc(8);
    chk(32'({serial_clock_pin_o, serial_data_out}), 32'h3);
    $display("mode table done");
    mode_pin <= 1'b1;
    pulse_rst();
    push(8'h3C);
    bus(1'b0, RDSRO_OFS_STATE, 32'h0);
    chk(32'(rd[15:8]), 32'h0);
    chk(32'(ready), 32'h0);
    bus(1'b1, RDSRO_OFS_ENABLE, 32'h1);
    signal_detect <= 1'b1;
    cyc(2);
    push(8'hA5);
    signal_detect <= 1'b0;
    push(8'h96);
    bus(1'b0, RDSRO_OFS_STATE, 32'h0);
    chk(32'(rd[15:8]), 32'h10);
    chk(32'({ready, irq}), 32'h3);
    bus(1'b1, RDSRO_OFS_CLEAR, 32'h1);
    bus(1'b1, RDSRO_OFS_STATUS, 32'hF);
    cyc(2);
    chk(32'(irq), 32'h0);
    mark = ncap;
    h_en <= 1'b1;
    wait_cap(16);
    chk(32'(got), 32'hA596);
    cyc(20);
    chk(32'(ready), 32'h0);
    h_en <= 1'b0;
    bus(1'b0, RDSRO_OFS_STATUS, 32'h0);
    chk(rd, 32'hA);
    bus(1'b1, RDSRO_OFS_ENABLE, 32'h8);
    cyc(2);
    chk(32'(irq), 32'h1);
    bus(1'b0, 5'h10, 32'h0);
    chk(rd, 32'h0);
    $display("slave readout done");
    signal_detect <= 1'b1;
    cyc(2);
    push(8'hFF);
    pulse_rst();
    bus(1'b0, RDSRO_OFS_STATE, 32'h0);
    chk(32'({rd[15:8], ready}), 32'h0);
    $display("reset pin done");
    cyc(2);
    push(8'hC3);
    mark = ncap;
    mode_pin <= 1'b0;
    wait_cap(3);
    // Switch at once after the third falling edge
    mode_pin <= 1'b1;
    cyc(6);
    h_en <= 1'b1;
    h_slow <= 1'b1;
    wait_cap(8);
    chk(32'(got[7:0]), 32'hC3);
    $display("mode switch done");
    mark = ncap;
    push(8'h5A);
    wait_cap(8);
    cyc(20);
    chk(32'(ready), 32'h0);
    // Back to master once the buffer has run dry
    h_en <= 1'b0;
    mode_pin <= 1'b0;
    push(8'h69);
    wait_cap(16);
    chk(32'(got), 32'h5A69);
    $display("slave to master done");
    h_en <= 1'b0;
    mode_pin <= 1'b0;
    signal_detect <= 1'b0;
    pulse_rst();
    cyc(8);
    chk(32'({serial_clock_pin_o, serial_data_out}), 32'h3);
    $display("master clear done");
    end_of_test();
  end
endmodule
